/* ict_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module ict_sequencer (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  // program memory
  input  wire logic                        mem_valid,
  input  wire logic [ict_pkg::WORD_W-1:0]  mem_rdata,
  output logic                             fetch_req,
  // interrupt
  input  wire logic                        irq_pending,
  output logic                             irq_ack,
  output logic                             handler_start,
  // retirement
  output logic                             instr_done,
  output logic [ict_pkg::WORD_W-1:0]       done_op,
  output ict_pkg::ict_timing_type          done_timing,
  // register update
  output logic                             reg_inc,
  output logic [3:0]                       reg_inc_idx
);

  typedef enum logic [1:0] {S_FETCH, S_EXEC, S_IRQ} ict_state_type;

  ict_state_type                 state_q;
  ict_state_type                 state_d;
  ict_pkg::ict_timing_type       dec_t;
  ict_pkg::ict_timing_type       t_q;
  ict_pkg::ict_timing_type       cur_t;
  logic [ict_pkg::WORD_W-1:0]    op_q;
  logic [ict_pkg::WORD_W-1:0]    cur_op;
  logic [3:0]                    rem_q;
  logic [1:0]                    ext_q;
  logic                          fetch_req_q;
  logic                          fetch_req_d;
  logic                          take;
  logic                          op_take;
  logic                          ext_take;
  logic                          stall;
  logic                          fin;
  logic                          irq_last;
  logic                          instr_done_q;
  logic                          irq_ack_q;
  logic                          handler_start_q;
  logic                          reg_inc_q;
  logic [3:0]                    reg_inc_idx_q;
  logic [ict_pkg::WORD_W-1:0]    done_op_q;
  ict_pkg::ict_timing_type       done_timing_q;

  ict_decode u_decode (
    .op     (mem_rdata),
    .timing (dec_t)
  );

  // memory handshake
  assign take     = fetch_req_q && mem_valid;
  assign op_take  = (state_q == S_FETCH) && take;
  assign ext_take = (state_q == S_EXEC) && take;
  // a stalled extension fetch does not count, so the total stays exact
  assign stall    = fetch_req_q && !mem_valid;
  assign irq_last = (state_q == S_IRQ) && (rem_q == '0);

  assign cur_t  = op_take ? dec_t : t_q;
  assign cur_op = op_take ? mem_rdata : op_q;

  // last counted cycle of the instruction
  always_comb begin
    fin = 1'b0;
    if (op_take && dec_t.cycles == ict_pkg::CYC_ONE) begin
      fin = 1'b1;
    end else if (state_q == S_EXEC && !stall && rem_q == ict_pkg::CYC_ONE) begin
      fin = 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_FETCH: begin
        if (op_take) begin
          state_d = S_EXEC;
        end
      end
      S_EXEC: begin
        state_d = S_EXEC;
      end
      S_IRQ: begin
        if (irq_last) begin
          state_d = S_FETCH;
        end
      end
    endcase
    // interrupts are accepted only between instructions
    if (fin) begin
      state_d = irq_pending ? S_IRQ : S_FETCH;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_FETCH;
    end else begin
      state_q <= state_d;
    end
  end

  // remaining cycles
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rem_q <= '0;
    end else if (fin && irq_pending) begin
      rem_q <= ict_pkg::IRQ_CYC - ict_pkg::CYC_ONE;
    end else if (op_take) begin
      rem_q <= dec_t.cycles - ict_pkg::CYC_ONE;
    end else if (state_q == S_EXEC && !stall) begin
      rem_q <= rem_q - ict_pkg::CYC_ONE;
    end else if (state_q == S_IRQ && !irq_last) begin
      rem_q <= rem_q - ict_pkg::CYC_ONE;
    end
  end

  // extension words still owed by memory
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext_q <= '0;
    end else if (op_take) begin
      ext_q <= dec_t.words - ict_pkg::WORDS_ONE;
    end else if (ext_take) begin
      ext_q <= ext_q - ict_pkg::WORDS_ONE;
    end
  end

  // fetch request
  always_comb begin
    fetch_req_d = fetch_req_q;
    unique case (state_q)
      S_FETCH: begin
        if (op_take) begin
          fetch_req_d = dec_t.words > ict_pkg::WORDS_ONE;
        end else begin
          fetch_req_d = 1'b1;
        end
      end
      S_EXEC: begin
        if (ext_take) begin
          fetch_req_d = ext_q > ict_pkg::WORDS_ONE;
        end
      end
      S_IRQ: begin
        fetch_req_d = irq_last;
      end
    endcase
    // next opcode fetch starts right after the last cycle unless an interrupt is pending
    if (fin) begin
      fetch_req_d = !irq_pending;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fetch_req_q <= 1'b0;
    end else begin
      fetch_req_q <= fetch_req_d;
    end
  end

  // current instruction
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      op_q <= '0;
      t_q  <= '0;
    end else if (op_take) begin
      op_q <= mem_rdata;
      t_q  <= dec_t;
    end
  end

  // retirement report
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      instr_done_q  <= 1'b0;
      done_op_q     <= '0;
      done_timing_q <= '0;
    end else begin
      instr_done_q <= fin;
      if (fin) begin
        done_op_q     <= cur_op;
        done_timing_q <= cur_t;
      end
    end
  end

  // pointer register bump after an autoincrement operand
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_inc_q     <= 1'b0;
      reg_inc_idx_q <= '0;
    end else begin
      reg_inc_q <= fin && cur_t.ainc;
      if (fin) begin
        reg_inc_idx_q <= cur_t.inc_reg;
      end
    end
  end

  // interrupt entry
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_ack_q       <= 1'b0;
      handler_start_q <= 1'b0;
    end else begin
      irq_ack_q       <= fin && irq_pending;
      handler_start_q <= irq_last;
    end
  end

  assign fetch_req     = fetch_req_q;
  assign irq_ack       = irq_ack_q;
  assign handler_start = handler_start_q;
  assign instr_done    = instr_done_q;
  assign done_op       = done_op_q;
  assign done_timing   = done_timing_q;
  assign reg_inc       = reg_inc_q;
  assign reg_inc_idx   = reg_inc_idx_q;

  // helper counters, read only by the checks below
  logic [3:0] cyc_seen_q;
  logic [1:0] words_seen_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cyc_seen_q   <= '0;
      words_seen_q <= '0;
    end else begin
      if (op_take) begin
        cyc_seen_q <= 4'h1;
      end else if (state_q == S_EXEC && !stall) begin
        cyc_seen_q <= 4'(cyc_seen_q + 4'h1);
      end
      if (op_take) begin
        words_seen_q <= 2'h1;
      end else if (ext_take) begin
        words_seen_q <= 2'(words_seen_q + 2'h1);
      end
    end
  end

  // fields of the retired word
  logic       d_f1;
  logic       d_f2;
  logic       d_jmp;
  logic       d_ad;
  logic [1:0] d_as;
  logic [2:0] d_sub;
  logic [3:0] d_src;
  logic [3:0] d_dst;

  assign d_f1  = done_op_q[15:12] >= ict_pkg::FI_MIN_OP;
  assign d_f2  = done_op_q[15:10] == ict_pkg::F2_PREFIX;
  assign d_jmp = done_op_q[15:13] == ict_pkg::JUMP_PREFIX;
  assign d_ad  = done_op_q[ict_pkg::AD_POS];
  assign d_as  = done_op_q[ict_pkg::AS_LSB +: 2];
  assign d_sub = done_op_q[ict_pkg::F2_LSB +: 3];
  assign d_src = done_op_q[ict_pkg::SRC_LSB +: 4];
  assign d_dst = done_op_q[ict_pkg::DST_LSB +: 4];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  chk_reg_reg: assert property (
    instr_done_q && d_f1 && d_as == 2'h0 && !d_ad && d_dst != 4'h0 && done_op_q[15:12] != 4'ha
    |-> done_timing_q.cycles == 4'h1 && done_timing_q.words == 2'h1)
    else $error("register to register timing wrong");

  chk_reg_pc: assert property (
    instr_done_q && d_f1 && d_as == 2'h0 && !d_ad && d_dst == 4'h0 && done_op_q[15:12] != 4'ha
    |-> done_timing_q.cycles == 4'h2 && done_timing_q.words == 2'h1)
    else $error("register into pc timing wrong");

  chk_idx_mem: assert property (
    instr_done_q && d_f1 && d_as == 2'h1 && d_ad && done_op_q[15:12] != 4'ha
    |-> done_timing_q.cycles == 4'h6 && done_timing_q.words == 2'h3)
    else $error("indexed to memory timing wrong");

  chk_imm_mem: assert property (
    instr_done_q && d_f1 && d_as == 2'h3 && d_src == 4'h0 && d_ad && done_op_q[15:12] != 4'ha
    |-> done_timing_q.cycles == 4'h5 && done_timing_q.words == 2'h3)
    else $error("immediate to memory timing wrong");

  chk_dec_extra: assert property (
    instr_done_q && done_op_q[15:12] == 4'ha && d_as == 2'h0 && !d_ad && d_dst != 4'h0
    |-> done_timing_q.cycles == 4'h2)
    else $error("decimal add extra cycle missing");

  chk_call_reg: assert property (
    instr_done_q && d_f2 && d_sub == 3'h5 && d_as == 2'h0
    |-> done_timing_q.cycles == 4'h4 && done_timing_q.words == 2'h1)
    else $error("call on register timing wrong");

  chk_jump_fixed: assert property (
    instr_done_q && d_jmp
    |-> done_timing_q.cycles == 4'h2 && done_timing_q.words == 2'h1)
    else $error("jump timing wrong");

  chk_irtn_fixed: assert property (
    instr_done_q && d_f2 && d_sub == 3'h6
    |-> done_timing_q.cycles == 4'h5 && done_timing_q.words == 2'h1)
    else $error("interrupt return timing wrong");

  sequence irq_quiet_seq;
    (!handler_start_q && !fetch_req_q) [*6];
  endsequence

  sequence irq_enter_seq;
    handler_start_q && fetch_req_q;
  endsequence

  chk_irq_entry: assert property (
    irq_ack_q |-> irq_quiet_seq ##1 irq_enter_seq)
    else $error("interrupt entry not six cycles");

  chk_next_fetch: assert property (
    instr_done_q && !irq_ack_q |-> fetch_req_q)
    else $error("no fetch after completion");

  chk_cycle_count: assert property (
    instr_done_q |-> cyc_seen_q == done_timing_q.cycles)
    else $error("counted cycles differ from timing");

  chk_word_count: assert property (
    instr_done_q |-> words_seen_q == done_timing_q.words)
    else $error("fetched words differ from length");

  chk_autoinc_step: assert property (
    instr_done_q && (d_f1 || d_f2) && d_as == 2'h3 && (d_f1 ? d_src : d_dst) != 4'h0
    && !(d_f2 && d_sub > 3'h5)
    |-> reg_inc_q && reg_inc_idx_q == (d_f1 ? d_src : d_dst))
    else $error("autoincrement register not bumped");

endmodule : ict_sequencer
`default_nettype wire

/* ict_pkg.sv */
package ict_pkg;

  localparam int WORD_W = 16;

  // opcode word field positions
  localparam int SRC_LSB = 8;
  localparam int AD_POS  = 7;
  localparam int AS_LSB  = 4;
  localparam int DST_LSB = 0;
  localparam int F2_LSB  = 7;

  // format selection
  localparam logic [3:0] FI_MIN_OP   = 4'h4;
  localparam logic [3:0] OP_DEC_ADD  = 4'ha;
  localparam logic [5:0] F2_PREFIX   = 6'h04;
  localparam logic [2:0] JUMP_PREFIX = 3'h1;
  localparam logic [3:0] PC_REG      = 4'h0;

  // single operand sub-opcodes
  localparam logic [2:0] F2_PUSH = 3'h4;
  localparam logic [2:0] F2_CALL = 3'h5;
  localparam logic [2:0] F2_IRTN = 3'h6;
  localparam logic [2:0] F2_ROT_MAX = 3'h3;

  // addressing modes
  localparam logic [1:0] MODE_REG  = 2'h0;
  localparam logic [1:0] MODE_IDX  = 2'h1;
  localparam logic [1:0] MODE_IND  = 2'h2;
  localparam logic [1:0] MODE_AINC = 2'h3;

  typedef enum logic [2:0] {CLS_REG, CLS_IDX, CLS_IND, CLS_AINC, CLS_IMM} ict_cls_type;
  typedef logic [3:0] ict_cyc_type;

  // cycle tables indexed by operand class
  localparam ict_cyc_type FI_REG_CYC [5] = '{4'h1, 4'h3, 4'h2, 4'h2, 4'h2};
  localparam ict_cyc_type FI_PC_CYC  [5] = '{4'h2, 4'h3, 4'h2, 4'h3, 4'h2};
  localparam ict_cyc_type FI_MEM_CYC [5] = '{4'h4, 4'h6, 4'h5, 4'h5, 4'h5};
  localparam ict_cyc_type F2_ROT_CYC [5] = '{4'h1, 4'h4, 4'h3, 4'h3, 4'h3};
  localparam ict_cyc_type F2_PUSH_CYC[5] = '{4'h3, 4'h5, 4'h4, 4'h4, 4'h4};
  localparam ict_cyc_type F2_CALL_CYC[5] = '{4'h4, 4'h5, 4'h4, 4'h5, 4'h5};

  localparam ict_cyc_type DEC_EXTRA  = 4'h1;
  localparam ict_cyc_type JUMP_CYC   = 4'h2;
  localparam ict_cyc_type IRTN_CYC   = 4'h5;
  localparam ict_cyc_type IRQ_CYC    = 4'h6;
  localparam ict_cyc_type UNDEF_CYC  = 4'h1;
  localparam ict_cyc_type CYC_ONE    = 4'h1;
  localparam logic [1:0]  WORDS_ONE  = 2'h1;

  typedef struct packed {
    logic [3:0] cycles;
    logic [1:0] words;
    logic       ainc;
    logic       illegal;
    logic [3:0] inc_reg;
  } ict_timing_type;

endpackage : ict_pkg

/* ict_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module ict_decode (
  // instruction word
  input  wire logic [ict_pkg::WORD_W-1:0] op,
  // timing result
  output ict_pkg::ict_timing_type          timing
);

  logic [3:0]           regn;
  logic [1:0]           mode;
  logic [2:0]           sub;
  logic                 is_f1;
  logic                 is_f2;
  logic                 is_jmp;
  logic                 ext_src;
  ict_pkg::ict_cls_type cls;

  always_comb begin
    is_f1  = op[15:12] >= ict_pkg::FI_MIN_OP;
    is_f2  = op[15:10] == ict_pkg::F2_PREFIX;
    is_jmp = op[15:13] == ict_pkg::JUMP_PREFIX;
    regn   = is_f1 ? op[ict_pkg::SRC_LSB +: 4] : op[ict_pkg::DST_LSB +: 4];
    mode   = op[ict_pkg::AS_LSB +: 2];
    sub    = op[ict_pkg::F2_LSB +: 3];
    unique case (mode)
      ict_pkg::MODE_REG:  cls = ict_pkg::CLS_REG;
      ict_pkg::MODE_IDX:  cls = ict_pkg::CLS_IDX;
      ict_pkg::MODE_IND:  cls = ict_pkg::CLS_IND;
      ict_pkg::MODE_AINC: cls = (regn == ict_pkg::PC_REG) ? ict_pkg::CLS_IMM : ict_pkg::CLS_AINC;
    endcase
    // extension words follow the opcode, one per indexed or immediate operand
    ext_src = (cls == ict_pkg::CLS_IDX) || (cls == ict_pkg::CLS_IMM);
    timing         = '0;
    timing.inc_reg = regn;
    timing.ainc    = cls == ict_pkg::CLS_AINC;
    if (is_f1) begin
      if (op[ict_pkg::AD_POS]) begin
        timing.cycles = ict_pkg::FI_MEM_CYC[cls];
      end else if (op[ict_pkg::DST_LSB +: 4] == ict_pkg::PC_REG) begin
        timing.cycles = ict_pkg::FI_PC_CYC[cls];
      end else begin
        timing.cycles = ict_pkg::FI_REG_CYC[cls];
      end
      if (op[15:12] == ict_pkg::OP_DEC_ADD) begin
        timing.cycles = timing.cycles + ict_pkg::DEC_EXTRA;
      end
      timing.words = ict_pkg::WORDS_ONE + 2'(ext_src) + 2'(op[ict_pkg::AD_POS]);
    end else if (is_f2) begin
      timing.words = ict_pkg::WORDS_ONE + 2'(ext_src);
      if (sub <= ict_pkg::F2_ROT_MAX) begin
        timing.cycles = ict_pkg::F2_ROT_CYC[cls];
      end else if (sub == ict_pkg::F2_PUSH) begin
        timing.cycles = ict_pkg::F2_PUSH_CYC[cls];
      end else if (sub == ict_pkg::F2_CALL) begin
        timing.cycles = ict_pkg::F2_CALL_CYC[cls];
      end else if (sub == ict_pkg::F2_IRTN) begin
        timing.cycles = ict_pkg::IRTN_CYC;
        timing.words  = ict_pkg::WORDS_ONE;
        timing.ainc   = 1'b0;
      end else begin
        timing.cycles  = ict_pkg::UNDEF_CYC;
        timing.words   = ict_pkg::WORDS_ONE;
        timing.ainc    = 1'b0;
        timing.illegal = 1'b1;
      end
    end else if (is_jmp) begin
      timing.cycles = ict_pkg::JUMP_CYC;
      timing.words  = ict_pkg::WORDS_ONE;
      timing.ainc   = 1'b0;
    end else begin
      // unassigned opcode space: retire in one cycle and flag it
      timing.cycles  = ict_pkg::UNDEF_CYC;
      timing.words   = ict_pkg::WORDS_ONE;
      timing.ainc    = 1'b0;
      timing.illegal = 1'b1;
    end
  end

endmodule : ict_decode
`default_nettype wire

/* ict_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module ict_prog_mem (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // fetch side
  input  wire logic        fetch_req,
  input  wire logic        slow,
  output logic             mem_valid,
  output logic [15:0]      mem_rdata
);
  // programs loaded here never put immediate mode in a destination field
  logic [15:0] rom [256];
  logic [7:0]  ptr_q;
  logic        phase_q;

  // slow mode answers every other cycle to stretch fetches
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  assign mem_valid = fetch_req && (!slow || phase_q);
  // idle data is inverted so a stale word never passes for a fresh one
  assign mem_rdata = mem_valid ? rom[ptr_q] : ~rom[ptr_q];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= 8'h00;
    end else if (fetch_req && mem_valid) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end
endmodule : ict_prog_mem
`default_nettype wire

/* instruction_cycle_timing_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_timing_tb;
  localparam logic [15:0] FILL = 16'h4404;

  logic                   core_clk    = 1'b0;
  logic                   rstn        = 1'b0;
  logic                   irq_pending = 1'b0;
  logic                   slow        = 1'b0;
  logic                   mem_valid;
  logic [15:0]            mem_rdata;
  logic                   fetch_req;
  logic                   irq_ack;
  logic                   handler_start;
  logic                   instr_done;
  logic [15:0]            done_op;
  ict_pkg::ict_timing_type done_timing;
  logic                   reg_inc;
  logic [3:0]             reg_inc_idx;
  int                     n_mismatch = 0;
  int                     tests_run  = 0;
  int                     wp;
  logic [15:0]            e_op [$];
  logic [3:0]             e_cyc [$];
  logic [1:0]             e_wd [$];
  logic                   e_inc [$];
  logic [3:0]             e_idx [$];
  logic                   e_ill [$];

  always #2.5 core_clk = ~core_clk;

  ict_sequencer i_dut (
    .core_clk      (core_clk),
    .rstn          (rstn),
    .mem_valid     (mem_valid),
    .mem_rdata     (mem_rdata),
    .fetch_req     (fetch_req),
    .irq_pending   (irq_pending),
    .irq_ack       (irq_ack),
    .handler_start (handler_start),
    .instr_done    (instr_done),
    .done_op       (done_op),
    .done_timing   (done_timing),
    .reg_inc       (reg_inc),
    .reg_inc_idx   (reg_inc_idx)
  );

  ict_prog_mem i_mem (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .fetch_req (fetch_req),
    .slow      (slow),
    .mem_valid (mem_valid),
    .mem_rdata (mem_rdata)
  );

  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  function automatic logic [15:0] f1(logic [3:0] opc, logic [3:0] src, logic ad,
                                     logic [1:0] as, logic [3:0] dst);
    return {opc, src, ad, 1'b0, as, dst};
  endfunction : f1

  function automatic logic [15:0] f2(logic [2:0] sub, logic [1:0] as, logic [3:0] r);
    return {6'h04, sub, 1'b0, as, r};
  endfunction : f2

  task automatic add(input logic [15:0] op, input logic [3:0] cyc, input logic [1:0] wd,
                     input logic inc, input logic [3:0] idx);
    e_op.push_back(op);
    e_cyc.push_back(cyc);
    e_wd.push_back(wd);
    e_inc.push_back(inc);
    e_idx.push_back(idx);
    e_ill.push_back(1'b0);
    i_mem.rom[wp] = op;
    wp++;
    // extension words carry arbitrary constants
    repeat (int'(wd) - 1) begin
      i_mem.rom[wp] = 16'h5a5a;
      wp++;
    end
  endtask : add

  // unassigned opcodes retire in one cycle with the illegal flag up
  task automatic add_ill(input logic [15:0] op);
    add(op, 4'h1, 2'h1, 1'b0, 4'h0);
    e_ill[e_ill.size() - 1] = 1'b1;
  endtask : add_ill

  task automatic clear();
    e_op.delete();
    e_cyc.delete();
    e_wd.delete();
    e_inc.delete();
    e_idx.delete();
    e_ill.delete();
    wp = 0;
    add(FILL, 4'h1, 2'h1, 1'b0, 4'h0);
  endtask : clear

  task automatic start_prog();
    for (int k = wp; k < wp + 16; k++) i_mem.rom[k] = FILL;
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
  endtask : start_prog

  task automatic run_prog(input bit chk_int);
    int i;
    int c;
    i = 0;
    c = 0;
    start_prog();
    for (int t = 0; t < 400 && i < e_op.size(); t++) begin
      @(posedge core_clk);
      #1;
      c++;
      if (instr_done === 1'b1) begin
        cmp_val(done_op, e_op[i]);
        cmp_val(16'(done_timing.cycles), 16'(e_cyc[i]));
        cmp_val(16'(done_timing.words), 16'(e_wd[i]));
        cmp_val(16'(done_timing.illegal), 16'(e_ill[i]));
        cmp_val(16'(reg_inc), 16'(e_inc[i]));
        if (e_inc[i]) cmp_val(16'(reg_inc_idx), 16'(e_idx[i]));
        if (chk_int && i > 0) cmp_val(16'(c), 16'(e_cyc[i]));
        c = 0;
        i++;
      end
    end
    if (i < e_op.size()) begin
      n_mismatch++;
      complete_run();
    end
  endtask : run_prog

  task automatic test_format1();
    clear();
    add(f1(4'h4, 4'h5, 1'b0, 2'h0, 4'h8), 4'h1, 2'h1, 1'b0, 4'h0);
    add(f1(4'h4, 4'h9, 1'b0, 2'h0, 4'h0), 4'h2, 2'h1, 1'b0, 4'h0);
    add(f1(4'h5, 4'h5, 1'b1, 2'h0, 4'h6), 4'h4, 2'h2, 1'b0, 4'h0);
    add(f1(4'h4, 4'h5, 1'b0, 2'h1, 4'h7), 4'h3, 2'h2, 1'b0, 4'h0);
    add(f1(4'h5, 4'h4, 1'b1, 2'h1, 4'h9), 4'h6, 2'h3, 1'b0, 4'h0);
    add(f1(4'h4, 4'h4, 1'b0, 2'h2, 4'h5), 4'h2, 2'h1, 1'b0, 4'h0);
    add(f1(4'h4, 4'h5, 1'b1, 2'h2, 4'h6), 4'h5, 2'h2, 1'b0, 4'h0);
    add(f1(4'h5, 4'h5, 1'b0, 2'h3, 4'h6), 4'h2, 2'h1, 1'b1, 4'h5);
    add(f1(4'h4, 4'h9, 1'b0, 2'h3, 4'h0), 4'h3, 2'h1, 1'b1, 4'h9);
    add(f1(4'h4, 4'h0, 1'b0, 2'h3, 4'h9), 4'h2, 2'h2, 1'b0, 4'h0);
    add(f1(4'h4, 4'h9, 1'b1, 2'h3, 4'h4), 4'h5, 2'h2, 1'b1, 4'h9);
    add(f1(4'h5, 4'h0, 1'b1, 2'h3, 4'h2), 4'h5, 2'h3, 1'b0, 4'h0);
    add(f1(4'ha, 4'h5, 1'b0, 2'h0, 4'h8), 4'h2, 2'h1, 1'b0, 4'h0);
    add(f1(4'ha, 4'h4, 1'b1, 2'h1, 4'h9), 4'h7, 2'h3, 1'b0, 4'h0);
    run_prog(1'b1);
  endtask : test_format1

  task automatic test_format2();
    logic [3:0] rot [5];
    logic [3:0] psh [5];
    logic [3:0] cal [5];
    logic [1:0] wds [5];
    logic [3:0] cyc;
    rot = '{4'h1, 4'h4, 4'h3, 4'h3, 4'h3};
    psh = '{4'h3, 4'h5, 4'h4, 4'h4, 4'h4};
    cal = '{4'h4, 4'h5, 4'h4, 4'h5, 4'h5};
    wds = '{2'h1, 2'h2, 2'h1, 2'h1, 2'h2};
    clear();
    // operand classes: register, indexed, indirect, autoincrement, immediate
    for (int m = 0; m < 5; m++) begin
      for (int s = 0; s < 6; s++) begin
        // rotate class writes its operand, so no immediate there
        if (m == 4 && s < 4) continue;
        cyc = (s < 4) ? rot[m] : ((s == 4) ? psh[m] : cal[m]);
        add(f2(3'(s), (m == 4) ? 2'h3 : 2'(m), (m == 4) ? 4'h0 : 4'h6),
            cyc, wds[m], m == 3, 4'h6);
      end
    end
    run_prog(1'b1);
  endtask : test_format2

  task automatic test_jumps();
    clear();
    for (int c = 0; c < 8; c++) add({3'h1, 3'(c), 10'h004}, 4'h2, 2'h1, 1'b0, 4'h0);
    add(f2(3'h6, 2'h0, 4'h0), 4'h5, 2'h1, 1'b0, 4'h0);
    add({3'h1, 3'h7, 10'h3fe}, 4'h2, 2'h1, 1'b0, 4'h0);
    add_ill(16'h0000);
    add_ill(f2(3'h7, 2'h0, 4'h5));
    run_prog(1'b1);
  endtask : test_jumps

  task automatic test_irq();
    int c;
    int t;
    clear();
    @(posedge core_clk);
    irq_pending <= 1'b1;
    start_prog();
    for (t = 0; t < 60 && instr_done !== 1'b1; t++) begin
      @(posedge core_clk);
      #1;
    end
    if (instr_done !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
    cmp_val(16'(irq_ack), 16'h0001);
    cmp_val(16'(fetch_req), 16'h0000);
    c = 0;
    for (t = 0; t < 20; t++) begin
      @(posedge core_clk);
      irq_pending <= 1'b0;
      #1;
      c++;
      if (handler_start === 1'b1) break;
      cmp_val(16'(fetch_req), 16'h0000);
    end
    if (handler_start !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
    cmp_val(16'(c), 16'h0006);
    cmp_val(16'(fetch_req), 16'h0001);
  endtask : test_irq

  task automatic test_stall();
    @(posedge core_clk);
    slow <= 1'b1;
    clear();
    // stalled fetch cycles must not show up in the counted cycles
    add(f1(4'h5, 4'h4, 1'b1, 2'h1, 4'h9), 4'h6, 2'h3, 1'b0, 4'h0);
    add(f2(3'h5, 2'h3, 4'h0), 4'h5, 2'h2, 1'b0, 4'h0);
    add(f1(4'h4, 4'h0, 1'b0, 2'h3, 4'h9), 4'h2, 2'h2, 1'b0, 4'h0);
    add({3'h1, 3'h2, 10'h010}, 4'h2, 2'h1, 1'b0, 4'h0);
    run_prog(1'b0);
    @(posedge core_clk);
    slow <= 1'b0;
  endtask : test_stall

  initial begin
    test_format1();
    test_format2();
    test_jumps();
    test_irq();
    test_stall();
    complete_run();
  end
endmodule : instruction_cycle_timing_tb
`default_nettype wire
